// file: hw/fcb_branch_unit.sv
// Flag conditional branch unit: condition test, target and timing
//
// Functional notes
// RL1 - Carry-clear and same-or-higher branch on carry 0
// RL2 - Lower branches when carry is 1
// RL3 - Minus branches when negative is 1
// RL4 - Plus branches when negative is 0
// RL5 - Signed ge branches when negative xor overflow 0
// RL6 - Signed lt branches when negative xor overflow 1
// RL7 - Half-carry-set branches when half carry 1
// RL8 - Half-carry-clear branches when half carry 0
// RL9 - Transfer-set branches when transfer flag 1
// RL10 - Taken target is pc plus offset plus one
// RL11 - No branch ever modifies status flags
// RL12 - One cycle not taken, two taken
// RL13 - Taken branch discards the already fetched instruction
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.svh"

module fcb_branch_unit #(
  parameter int PC_W  = `FCB_PC_W,
  parameter int OFF_W = `FCB_OFF_W,
  parameter int CNT_W = `FCB_CNT_W
) (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 req_valid_in,
  input  wire logic [`FCB_OP_W-1:0] op_in,
  input  wire logic [OFF_W-1:0]     offset_in,
  input  wire logic [PC_W-1:0]      pc_in,
  input  wire logic                 carry_in,
  input  wire logic                 negative_in,
  input  wire logic                 overflow_in,
  input  wire logic                 half_carry_in,
  input  wire logic                 transfer_in,
  output logic                      ready_out,
  output logic                      done_out,
  output logic                      taken_out,
  output logic                      pc_load_out,
  output logic [PC_W-1:0]           pc_target_out,
  output logic                      flush_out,
  output logic                      flags_we_out,
  output logic                      illegal_op_out,
  output logic [`FCB_CYC_W-1:0]     cycles_out,
  output logic [`FCB_OP_W-1:0]      last_op_out,
  output logic [CNT_W-1:0]          branch_count_out,
  output logic [CNT_W-1:0]          taken_count_out
);

  localparam int CYCW = `FCB_CYC_W;
  localparam int OPW  = `FCB_OP_W;

  // Parameter checks at elaboration; the offset must fit the program counter
  if (OFF_W < 2) begin : g_bad_off_narrow
    $error("fcb_branch_unit: OFF_W below 2");
  end
  if (PC_W < OFF_W) begin : g_bad_off_wide
    $error("fcb_branch_unit: OFF_W wider than PC_W");
  end
  if (PC_W > 32) begin : g_bad_pc_wide
    $error("fcb_branch_unit: PC_W above 32");
  end
  if (CNT_W < 1) begin : g_bad_cnt_narrow
    $error("fcb_branch_unit: CNT_W below 1");
  end
  if (CNT_W > 32) begin : g_bad_cnt_wide
    $error("fcb_branch_unit: CNT_W above 32");
  end
  // Cycle field must hold the taken cost
  if ((1 << CYCW) <= `FCB_CYC_TAKEN) begin : g_bad_cyc_field
    $error("fcb_branch_unit: cycle field too narrow");
  end
  // The sequencer assumes the taken path is the longer one
  if (`FCB_CYC_TAKEN <= `FCB_CYC_NOT_TAKEN) begin : g_bad_cost
    $error("fcb_branch_unit: taken cost not above not-taken cost");
  end
  // Every branch kind needs an op code
  if ((1 << OPW) < `FCB_NUM_OPS) begin : g_bad_op_field
    $error("fcb_branch_unit: op field too narrow");
  end

  // Condition evaluation
  logic cond_taken;
  logic cond_legal;

  fcb_cond_eval u_cond (
    .op_in         (op_in),
    .carry_in      (carry_in),
    .negative_in   (negative_in),
    .overflow_in   (overflow_in),
    .half_carry_in (half_carry_in),
    .transfer_in   (transfer_in),
    .taken_out     (cond_taken),
    .legal_out     (cond_legal)
  );

  // Target arithmetic wraps modulo the program space
  logic [PC_W-1:0] offset_ext;
  logic [PC_W-1:0] target;

  // Sign extension of the offset, one slot per program counter bit
  for (genvar b = 0; b < PC_W; b++) begin : g_sext
    if (b < OFF_W) begin : g_low
      assign offset_ext[b] = offset_in[b];
    end else begin : g_high
      assign offset_ext[b] = offset_in[OFF_W-1];
    end
  end

  assign target = PC_W'(pc_in + offset_ext + PC_W'(`FCB_PC_STEP)); // RL10

  // Sequencer state
  fcb_pkg::fcb_state_t state;
  fcb_pkg::fcb_state_t next_state;
  logic [CYCW-1:0]     cyc;
  logic [CYCW-1:0]     next_cyc;
  logic [CYCW-1:0]     cyc_step;
  logic                accept;
  logic                start;
  logic                take_now;
  logic                skip_now;
  logic                finish_taken;

  // Requests are only taken while ready is shown
  assign accept   = req_valid_in & ready_out;
  assign cyc_step = CYCW'(cyc + CYCW'(1));

  // Registered outputs
  logic                 next_ready;
  logic                 next_done;
  logic                 next_taken;
  logic                 next_pc_load;
  logic [PC_W-1:0]      next_pc_target;
  logic                 next_flush;
  logic                 next_flags_we;
  logic                 next_illegal;
  logic [CYCW-1:0]      next_cycles;
  logic [`FCB_OP_W-1:0] next_last_op;
  logic [CNT_W-1:0]     next_branch_count;
  logic [CNT_W-1:0]     next_taken_count;

  // What this cycle does, shared by every group below
  always_comb begin
    start        = accept & (state == fcb_pkg::FCB_ST_IDLE);
    take_now     = start & cond_legal & cond_taken;
    // Unknown code acts as a branch never taken
    skip_now     = start & ~take_now;
    finish_taken = (state == fcb_pkg::FCB_ST_TAKEN) & (cyc_step == CYCW'(`FCB_CYC_TAKEN));
  end

  // Sequencer: the taken state owes the second cycle
  always_comb begin
    next_state = state;
    next_cyc   = cyc;
    case (state)
      fcb_pkg::FCB_ST_IDLE: begin
        if (take_now) begin
          next_state = fcb_pkg::FCB_ST_TAKEN;                          // RL12
          next_cyc   = CYCW'(`FCB_CYC_NOT_TAKEN);
        end
      end
      fcb_pkg::FCB_ST_TAKEN: begin
        next_cyc = cyc_step;
        if (finish_taken) begin
          next_state = fcb_pkg::FCB_ST_IDLE;                           // RL12
          next_cyc   = '0;
        end
      end
      default: begin
        next_state = fcb_pkg::FCB_ST_IDLE;
        next_cyc   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= fcb_pkg::FCB_ST_IDLE;
      cyc   <= '0;
    end else begin
      state <= next_state;
      cyc   <= next_cyc;
    end
  end

  // Decoder is held off while the second cycle is owed
  always_comb begin
    next_ready = (next_state == fcb_pkg::FCB_ST_IDLE);                 // RL13
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= next_ready;
    end
  end

  // One-cycle strobes
  always_comb begin
    next_done     = skip_now | finish_taken;                           // RL12
    next_taken    = finish_taken;                                      // RL12
    next_pc_load  = take_now;                                          // RL10
    // Fetch stream is thrown away together with the load
    next_flush    = take_now;                                          // RL13
    next_illegal  = skip_now & ~cond_legal;
    // Flags are read only here; the write strobe never rises
    next_flags_we = 1'b0;                                              // RL11
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      done_out       <= 1'b0;
      taken_out      <= 1'b0;
      pc_load_out    <= 1'b0;
      flush_out      <= 1'b0;
      flags_we_out   <= 1'b0;
      illegal_op_out <= 1'b0;
    end else begin
      done_out       <= next_done;
      taken_out      <= next_taken;
      pc_load_out    <= next_pc_load;
      flush_out      <= next_flush;
      flags_we_out   <= next_flags_we;
      illegal_op_out <= next_illegal;
    end
  end

  // Target holds until the next taken branch
  always_comb begin
    next_pc_target = pc_target_out;
    if (take_now) begin
      next_pc_target = target;                                         // RL10
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pc_target_out <= '0;
    end else begin
      pc_target_out <= next_pc_target;
    end
  end

  // Cost and op of the branch last seen
  always_comb begin
    next_cycles  = cycles_out;
    next_last_op = last_op_out;
    if (start) begin
      next_last_op = op_in;
    end
    if (skip_now) begin
      next_cycles = CYCW'(`FCB_CYC_NOT_TAKEN);                         // RL12
    end else if (finish_taken) begin
      next_cycles = CYCW'(`FCB_CYC_TAKEN);                             // RL12
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cycles_out  <= '0;
      last_op_out <= '0;
    end else begin
      cycles_out  <= next_cycles;
      last_op_out <= next_last_op;
    end
  end

  // Accepted branches, illegal codes included; wraps at its width
  always_comb begin
    next_branch_count = branch_count_out;
    if (start) begin
      next_branch_count = CNT_W'(branch_count_out + CNT_W'(1));
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      branch_count_out <= '0;
    end else begin
      branch_count_out <= next_branch_count;
    end
  end

  // Taken branches only; wraps at its width
  always_comb begin
    next_taken_count = taken_count_out;
    if (take_now) begin
      next_taken_count = CNT_W'(taken_count_out + CNT_W'(1));
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      taken_count_out <= '0;
    end else begin
      taken_count_out <= next_taken_count;
    end
  end

endmodule

`default_nettype wire

// file: hw/fcb_cond_eval.sv
// Branch condition evaluation from the status flags
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.svh"

module fcb_cond_eval (
  input  wire logic [`FCB_OP_W-1:0] op_in,
  input  wire logic                 carry_in,
  input  wire logic                 negative_in,
  input  wire logic                 overflow_in,
  input  wire logic                 half_carry_in,
  input  wire logic                 transfer_in,
  output logic                      taken_out,
  output logic                      legal_out
);

  localparam int OPW = `FCB_OP_W;
  localparam int NOPS = `FCB_NUM_OPS;

  logic [NOPS-1:0] cond_vec;
  logic [NOPS-1:0] hit;
  logic            signed_lt;

  assign signed_lt = negative_in ^ overflow_in;

  assign cond_vec[`FCB_OP_CARRY_CLEAR]  = (carry_in == `FCB_COND_CLEAR);      // RL1
  assign cond_vec[`FCB_OP_UNSIGNED_GE]  = (carry_in == `FCB_COND_CLEAR);      // RL1
  assign cond_vec[`FCB_OP_UNSIGNED_LT]  = (carry_in == `FCB_COND_SET);        // RL2
  assign cond_vec[`FCB_OP_NEGATIVE]     = (negative_in == `FCB_COND_SET);     // RL3
  assign cond_vec[`FCB_OP_NONNEGATIVE]  = (negative_in == `FCB_COND_CLEAR);   // RL4
  assign cond_vec[`FCB_OP_SIGNED_GE]    = (signed_lt == `FCB_COND_CLEAR);     // RL5
  assign cond_vec[`FCB_OP_SIGNED_LT]    = (signed_lt == `FCB_COND_SET);       // RL6
  assign cond_vec[`FCB_OP_HALF_SET]     = (half_carry_in == `FCB_COND_SET);   // RL7
  assign cond_vec[`FCB_OP_HALF_CLEAR]   = (half_carry_in == `FCB_COND_CLEAR); // RL8
  assign cond_vec[`FCB_OP_TRANSFER_SET] = (transfer_in == `FCB_COND_SET);     // RL9

  // One decode slot per branch kind
  for (genvar i = 0; i < NOPS; i++) begin : g_sel
    assign hit[i] = (op_in == OPW'(i)) & cond_vec[i];
  end

  assign taken_out = |hit;
  assign legal_out = (op_in < OPW'(NOPS));

endmodule

`default_nettype wire

// file: hw/fcb_map.svh
// Constants for the flag conditional branch unit
`ifndef FCB_MAP_SVH
`define FCB_MAP_SVH

`define FCB_OP_W            4
`define FCB_NUM_OPS         10
`define FCB_OP_CARRY_CLEAR  4'h0
`define FCB_OP_UNSIGNED_GE  4'h1
`define FCB_OP_UNSIGNED_LT  4'h2
`define FCB_OP_NEGATIVE     4'h3
`define FCB_OP_NONNEGATIVE  4'h4
`define FCB_OP_SIGNED_GE    4'h5
`define FCB_OP_SIGNED_LT    4'h6
`define FCB_OP_HALF_SET     4'h7
`define FCB_OP_HALF_CLEAR   4'h8
`define FCB_OP_TRANSFER_SET 4'h9

`define FCB_PC_W            16
`define FCB_OFF_W           7
`define FCB_CNT_W           16
`define FCB_PC_STEP         1
`define FCB_CYC_NOT_TAKEN   1
`define FCB_CYC_TAKEN       2
`define FCB_CYC_W           2
`define FCB_COND_SET        1'b1
`define FCB_COND_CLEAR      1'b0

`endif

// file: hw/fcb_pkg.sv
// Types shared by the flag conditional branch unit
`include "fcb_map.svh"

package fcb_pkg;

  typedef enum logic [`FCB_OP_W-1:0] {
    FCB_BRANCH_CARRY_CLEAR      = `FCB_OP_CARRY_CLEAR,
    FCB_BRANCH_UNSIGNED_GE      = `FCB_OP_UNSIGNED_GE,
    FCB_BRANCH_UNSIGNED_LT      = `FCB_OP_UNSIGNED_LT,
    FCB_BRANCH_NEGATIVE         = `FCB_OP_NEGATIVE,
    FCB_BRANCH_NONNEGATIVE      = `FCB_OP_NONNEGATIVE,
    FCB_BRANCH_SIGNED_GE        = `FCB_OP_SIGNED_GE,
    FCB_BRANCH_SIGNED_LT        = `FCB_OP_SIGNED_LT,
    FCB_BRANCH_HALF_CARRY_SET   = `FCB_OP_HALF_SET,
    FCB_BRANCH_HALF_CARRY_CLEAR = `FCB_OP_HALF_CLEAR,
    FCB_BRANCH_TRANSFER_BIT_SET = `FCB_OP_TRANSFER_SET
  } fcb_op_t;

  typedef enum logic [0:0] {
    FCB_ST_IDLE  = 1'b0,
    FCB_ST_TAKEN = 1'b1
  } fcb_state_t;

endpackage

// file: tb/fcb_branch_unit_assertions.sv
// Concurrent checks on the branch unit ports
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.svh"
module fcb_branch_unit_assertions #(
  parameter int PC_W  = `FCB_PC_W,
  parameter int OFF_W = `FCB_OFF_W
) (
  input wire logic                 clk_in,
  input wire logic                 resetn_in,
  input wire logic                 req_valid_in,
  input wire logic [`FCB_OP_W-1:0] op_in,
  input wire logic [OFF_W-1:0]     offset_in,
  input wire logic [PC_W-1:0]      pc_in,
  input wire logic                 carry_in,
  input wire logic                 negative_in,
  input wire logic                 overflow_in,
  input wire logic                 half_carry_in,
  input wire logic                 transfer_in,
  input wire logic                 ready_out,
  input wire logic                 done_out,
  input wire logic                 taken_out,
  input wire logic                 pc_load_out,
  input wire logic [PC_W-1:0]      pc_target_out,
  input wire logic                 flush_out,
  input wire logic                 flags_we_out,
  input wire logic                 illegal_op_out,
  input wire logic [`FCB_CYC_W-1:0] cycles_out
);
  logic [9:0]      cv;
  logic            acc;
  logic            cond;
  logic [PC_W-1:0] tgt;
  logic            nv;
  assign nv = negative_in ^ overflow_in;
  assign cv = {transfer_in, ~half_carry_in, half_carry_in, nv, ~nv, ~negative_in, negative_in, carry_in, ~carry_in,
               ~carry_in};
  assign acc = req_valid_in && ready_out;
  assign cond = (op_in > 4'h9) ? 1'b0 : cv[op_in];
  assign tgt = pc_in + {{(PC_W-OFF_W){offset_in[OFF_W-1]}}, offset_in} + PC_W'(1);

  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  flags_kept_a: assert property (flags_we_out == 1'b0)
    else $error("status write strobe raised");
  flush_with_load_a: assert property (pc_load_out == flush_out)
    else $error("flush not paired with pc load");
  target_value_a: assert property (acc && cond |=> pc_load_out && pc_target_out == $past(tgt))
    else $error("taken target wrong");
  taken_timing_a: assert property (acc && cond |=> !done_out ##1 done_out && taken_out && cycles_out == 2'h2)
    else $error("taken branch timing wrong");
  not_taken_timing_a: assert property (acc && !cond |=> done_out && !taken_out && !pc_load_out && cycles_out == 2'h1)
    else $error("not taken branch timing wrong");
  stall_after_load_a: assert property (pc_load_out |-> !ready_out ##1 ready_out)
    else $error("stall after taken branch wrong");
  illegal_pulse_a: assert property (acc && op_in > 4'h9 |=> illegal_op_out && done_out && !taken_out)
    else $error("illegal op not flagged");
  taken_follows_load_a: assert property (taken_out |-> $past(pc_load_out) && !pc_load_out)
    else $error("taken pulse without prior pc load");
endmodule

bind fcb_branch_unit fcb_branch_unit_assertions #(.PC_W(PC_W), .OFF_W(OFF_W)) fcb_branch_unit_assertions_i (
  .clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in), .op_in(op_in), .offset_in(offset_in),
  .pc_in(pc_in), .carry_in(carry_in), .negative_in(negative_in), .overflow_in(overflow_in),
  .half_carry_in(half_carry_in), .transfer_in(transfer_in), .ready_out(ready_out), .done_out(done_out),
  .taken_out(taken_out), .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .flush_out(flush_out),
  .flags_we_out(flags_we_out), .illegal_op_out(illegal_op_out), .cycles_out(cycles_out));
`default_nettype wire

// file: tb/tb_fcb_branch_unit.sv
// Self-checking bench for the branch unit
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.svh"
module tb_fcb_branch_unit;
  typedef struct packed {logic tk; logic il; logic [15:0] tg; logic [3:0] op;} fcb_note_t;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        req_valid_in = 1'b0;
  logic [3:0]  op_in = 4'h0;
  logic [6:0]  offset_in = 7'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [4:0]  fl = 5'h00;
  logic        ready_out, done_out, taken_out, pc_load_out, flush_out, flags_we_out, illegal_op_out;
  logic [15:0] pc_target_out, branch_count_out, taken_count_out, n_sent, n_tk, cyc;
  logic [1:0]  cycles_out;
  logic [3:0]  last_op_out;
  int          n_fail = 0;
  int          cmp_count = 0;
  fcb_note_t   notes[$];
  fcb_note_t   nt;

  fcb_branch_unit fcb_branch_unit_i (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
    .op_in(op_in), .offset_in(offset_in), .pc_in(pc_in), .carry_in(fl[0]), .negative_in(fl[1]),
    .overflow_in(fl[2]), .half_carry_in(fl[3]), .transfer_in(fl[4]), .ready_out(ready_out), .done_out(done_out),
    .taken_out(taken_out), .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .flush_out(flush_out),
    .flags_we_out(flags_we_out), .illegal_op_out(illegal_op_out), .cycles_out(cycles_out),
    .last_op_out(last_op_out), .branch_count_out(branch_count_out), .taken_count_out(taken_count_out));

  always #50 clk_in = ~clk_in;

  function automatic fcb_note_t expect_of(logic [3:0] op, logic [6:0] off, logic [15:0] pc, logic [4:0] f);
    logic [9:0] v;
    v = {f[4], ~f[3], f[3], f[1] ^ f[2], ~(f[1] ^ f[2]), ~f[1], f[1], f[0], ~f[0], ~f[0]};
    expect_of.il = (op > 4'h9);
    expect_of.tk = expect_of.il ? 1'b0 : v[op];
    expect_of.tg = pc + {{9{off[6]}}, off} + 16'h0001;
    expect_of.op = op;
  endfunction

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Request stays up through a stall, so refused cycles are exercised too
  task automatic send(input logic [3:0] op, input logic [6:0] off, input logic [15:0] pc, input logic [4:0] f);
    logic acc;
    req_valid_in <= 1'b1;
    op_in <= op;
    offset_in <= off;
    pc_in <= pc;
    fl <= f;
    acc = 1'b0;
    while (!acc) begin
      @(negedge clk_in);
      acc = ready_out;
      @(posedge clk_in);
    end
    nt = expect_of(op, off, pc, f);
    notes.push_back(nt);
    n_sent++;
    n_tk = n_tk + {15'h0000, nt.tk};
  endtask

  always @(negedge clk_in) begin
    if (resetn_in) begin
      check("flag write", 16'h0000, {15'h0000, flags_we_out});
      if (pc_load_out && notes.size() > 0) begin
        check("target", notes[0].tg, pc_target_out);
        check("flush", 16'h0001, {15'h0000, flush_out});
      end
      if (done_out) begin
        if (notes.size() == 0) check("spare done", 16'h0000, 16'h0001);
        else begin
          nt = notes.pop_front();
          check("taken", {15'h0000, nt.tk}, {15'h0000, taken_out});
          check("cycles", nt.tk ? 16'h0002 : 16'h0001, {14'h0000, cycles_out});
          check("illegal", {15'h0000, nt.il}, {15'h0000, illegal_op_out});
          check("last op", {12'h000, nt.op}, {12'h000, last_op_out});
        end
      end
    end
  end

  always @(posedge clk_in) begin
    cyc <= cyc + 16'h0001;
    if (cyc == 16'h1388) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    cyc = 16'h0000;
    n_sent = 16'h0000;
    n_tk = 16'h0000;
    void'($urandom(32'h6b7b));
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 32; i++) send(4'(i), 7'h05, 16'h1000, i[4] ? 5'h1f : 5'h00);
    send(4'h0, 7'h3f, 16'hffff, 5'h00);
    send(4'h3, 7'h40, 16'h0000, 5'h02);
    repeat (300) send(4'($urandom), 7'($urandom), 16'($urandom), 5'($urandom));
    req_valid_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    check("pending", 16'h0000, 16'(notes.size()));
    check("branch count", n_sent, branch_count_out);
    check("taken count", n_tk, taken_count_out);
    final_report();
  end
endmodule
`default_nettype wire
